// [logic/module_ctrl_pkg.sv]
// package: constants and types for the module reset and transmit control
`default_nettype none
package module_ctrl_pkg;

   // clock rate and timing figures
   localparam int unsigned CLK_MHZ           = 200;
   localparam int unsigned INIT_TIME_US      = 100;
   localparam int unsigned INIT_CYCLES_DEF   = INIT_TIME_US * CLK_MHZ;
   localparam int unsigned TX_OFF_MAX_US     = 100;
   localparam int unsigned TX_OFF_MAX_CYCLES = TX_OFF_MAX_US * CLK_MHZ;
   localparam int unsigned RESET_MIN_US      = 1000;
   localparam int unsigned RESET_MIN_CYCLES  = RESET_MIN_US * CLK_MHZ;

   // management device slots: 1, 2, 3, 4, 30, 31
   localparam int unsigned DEV_SLOTS    = 6;
   localparam int unsigned DEV1_SLOT    = 0;
   localparam logic [5:0]  DEV_IMPL_DEF = 6'h3F;

   // synchronised pin vector layout
   localparam int unsigned PORT_ADDR_W  = 5;
   localparam int unsigned SYNC_W       = 7;
   localparam int unsigned SYNC_RST_POS = 6;
   localparam int unsigned SYNC_TXE_POS = 5;
   localparam logic [6:0]  SYNC_RST_VAL = 7'h60;

   // apb register map (byte addresses)
   localparam int unsigned APB_AW     = 8;
   localparam logic [7:0]  REG_CTRL   = 8'h00;
   localparam logic [7:0]  REG_STATUS = 8'h04;
   localparam logic [7:0]  REG_CLEAR  = 8'h08;
   localparam logic [7:0]  REG_ENABLE = 8'h0C;
   localparam logic [7:0]  REG_STATE  = 8'h10;

   // control register fields and reset values
   localparam int unsigned CTRL_RESET_BIT = 15;
   localparam int unsigned CTRL_LPS_BIT   = 0;
   localparam logic        CTRL_LPS_RST   = 1'b0;

   // event bits of status, clear and enable
   localparam int unsigned EV_W          = 4;
   localparam int unsigned EV_INIT_DONE  = 0;
   localparam int unsigned EV_PIN_RESET  = 1;
   localparam int unsigned EV_TX_OFF     = 2;
   localparam int unsigned EV_LINK_FAULT = 3;
   localparam logic [3:0]  ENABLE_RST    = 4'h0;

   // state register fields
   localparam int unsigned ST_RSTBITS_LSB = 0;
   localparam int unsigned ST_PORT_LSB    = 8;
   localparam int unsigned ST_SEQ_LSB     = 16;
   localparam int unsigned ST_LOWPWR_BIT  = 20;
   localparam int unsigned ST_TXON_BIT    = 21;
   localparam int unsigned ST_DPEN_BIT    = 22;
   localparam int unsigned ST_PINRST_BIT  = 23;
   localparam int unsigned ST_PINTXE_BIT  = 24;

   // reset and initialisation sequencer
   typedef enum logic [1:0] {
      SEQ_RUN     = 2'b00,
      SEQ_PIN_LOW = 2'b01,
      SEQ_HELD    = 2'b10,
      SEQ_INIT    = 2'b11
   } seq_state_type;

   // decoded register select
   typedef enum logic [2:0] {
      SEL_CTRL   = 3'b000,
      SEL_STATUS = 3'b001,
      SEL_CLEAR  = 3'b010,
      SEL_ENABLE = 3'b011,
      SEL_STATE  = 3'b100,
      SEL_NONE   = 3'b111
   } reg_sel_type;

endpackage : module_ctrl_pkg
`default_nettype wire

// [logic/module_reset_and_tx_control.sv]
// module side reset sequencer, transmitter gating and slow status pins
//
// Summary of operation
// - After initialisation every implemented device's reset bit is cleared.
// - The host resets the module by the reset pin or by writing bit 15.
// - After either reset the module initialises, then clears the bits.
// - Pin low sets the device-1 bit next; pin low with bit set holds reset.
// - The reset pin is active low: high runs, low resets.
// - Transmit-enable low turns the optical output off within 100 us.
// - Transmit-enable high allows transmit; low forces it off always.
// - The link alarm is active low, released high in normal operation.
// - Five port address pins, bit 4 down to 0, low reads as zero.
// - The module-present line is held low at all times while inserted.
// - Slow status lines are open-drain, never actively driven high.
// - Reset and transmit-enable have pull-ups, so undriven reads high.
// - The port address is loaded from the pins and matched on access.
// - With low-power startup, transmit-enable low keeps the module idle.
`timescale 1ns/10ps
`default_nettype none
module module_reset_and_tx_control #(
   parameter int unsigned INIT_CYCLES = module_ctrl_pkg::INIT_CYCLES_DEF,
   parameter logic [5:0]  DEV_IMPL    = module_ctrl_pkg::DEV_IMPL_DEF
) (
   // clock, reset and clock enable
   input  wire logic                                pclk,
   input  wire logic                                presetn,
   input  wire logic                                ce,
   // apb slave
   input  wire logic                                psel,
   input  wire logic                                penable,
   input  wire logic                                pwrite,
   input  wire logic [module_ctrl_pkg::APB_AW-1:0]  paddr,
   input  wire logic [31:0]                         pwdata,
   input  wire logic [3:0]                          pstrb,
   output logic      [31:0]                         prdata,
   output logic                                     pready,
   output logic                                     pslverr,
   // host control pins, resolved levels
   input  wire logic                                reset_pin_n,
   input  wire logic                                tx_enable_pin,
   input  wire logic                                port_address_bit4,
   input  wire logic                                port_address_bit3,
   input  wire logic                                port_address_bit2,
   input  wire logic                                port_address_bit1,
   input  wire logic                                port_address_bit0,
   // open-drain status pins
   output logic                                     link_alarm_line_out,
   output logic                                     link_alarm_line_oe,
   output logic                                     module_present_line_out,
   output logic                                     module_present_line_oe,
   // optics and management core
   input  wire logic                                link_fault,
   input  wire logic [module_ctrl_pkg::PORT_ADDR_W-1:0] mgmt_target_addr,
   output logic                                     mgmt_addr_match,
   output logic      [module_ctrl_pkg::PORT_ADDR_W-1:0] port_address,
   output logic      [module_ctrl_pkg::DEV_SLOTS-1:0]   dev_reset_bits,
   output logic                                     tx_laser_on,
   output logic                                     datapath_enable,
   output logic                                     low_power_active,
   // interrupt
   output logic                                     irq
);
   import module_ctrl_pkg::*;

   typedef struct packed {
      seq_state_type          seq;
      logic [DEV_SLOTS-1:0]   rst_bits;
      logic [31:0]            init_cnt;
      logic                   low_power;
      logic                   lps_en;
      logic [PORT_ADDR_W-1:0] port_addr;
      logic                   addr_match;
      logic                   tx_on;
      logic                   dp_en;
      logic                   present;
      logic                   txe_prev;
      logic                   fault_prev;
      logic [EV_W-1:0]        status;
      logic [EV_W-1:0]        enable;
      logic [31:0]            rdata;
   } ctl_state_type;

   ctl_state_type cur_ff;
   ctl_state_type nxt_ff;

   logic [SYNC_W-1:0]      pins_raw;
   logic [SYNC_W-1:0]      pins_s;
   logic                   pin_rst_n_s;
   logic                   pin_txe_s;
   logic [PORT_ADDR_W-1:0] pin_addr_s;
   reg_sel_type            sel;
   logic                   wr_acc;
   logic                   rd_setup;
   logic                   soft_reset;
   logic [31:0]            wmask;
   logic [EV_W-1:0]        events;
   logic                   init_done;
   logic                   alarm;

   // map a byte address onto a register select
   function automatic reg_sel_type decode_reg(
      input logic [APB_AW-1:0] addr
   );
      reg_sel_type r;
      r = SEL_NONE;
      unique case (addr)
         REG_CTRL:   r = SEL_CTRL;
         REG_STATUS: r = SEL_STATUS;
         REG_CLEAR:  r = SEL_CLEAR;
         REG_ENABLE: r = SEL_ENABLE;
         REG_STATE:  r = SEL_STATE;
         default:    r = SEL_NONE;
      endcase
      return r;
   endfunction : decode_reg

   // expand byte strobes into a bit mask
   function automatic logic [31:0] strobe_mask(input logic [3:0] strb);
      logic [31:0] m;
      m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
      return m;
   endfunction : strobe_mask

   // address bit 4 down to bit 0, low level is zero
   assign pins_raw = {reset_pin_n, tx_enable_pin,
                      port_address_bit4, port_address_bit3,
                      port_address_bit2, port_address_bit1,
                      port_address_bit0};

   // undriven pins idle high, so reset pre-loads run and enabled
   pin_sync #(
      .WIDTH     (SYNC_W),
      .RESET_VAL (SYNC_RST_VAL)
   ) u_pin_sync (
      .pclk      (pclk),
      .presetn   (presetn),
      .ce        (ce),
      .pins_in   (pins_raw),
      .pins_sync (pins_s)
   );

   assign pin_rst_n_s = pins_s[SYNC_RST_POS];
   assign pin_txe_s   = pins_s[SYNC_TXE_POS];
   assign pin_addr_s  = pins_s[PORT_ADDR_W-1:0];

   // apb decode; zero wait states, access phase always completes
   assign sel      = decode_reg(paddr);
   assign wr_acc   = psel & penable & pwrite;
   assign rd_setup = psel & ~penable & ~pwrite;
   assign wmask    = strobe_mask(pstrb);
   assign pready   = 1'b1;
   assign pslverr  = psel & penable & (decode_reg(paddr) == SEL_NONE);

   // writing one to the reset bit starts an in-place reset
   assign soft_reset = wr_acc & (sel == SEL_CTRL) &
                       pwdata[CTRL_RESET_BIT] &
                       wmask[CTRL_RESET_BIT];

   assign init_done = (cur_ff.seq == SEQ_INIT) &
                      (cur_ff.init_cnt == 32'(INIT_CYCLES - 1)) &
                      pin_rst_n_s & ~soft_reset;

   // sticky event sources
   always_comb begin
      events                = '0;
      events[EV_INIT_DONE]  = init_done;
      events[EV_PIN_RESET]  = (cur_ff.seq == SEQ_RUN) & ~pin_rst_n_s;
      events[EV_TX_OFF]     = cur_ff.txe_prev & ~pin_txe_s;
      events[EV_LINK_FAULT] = link_fault & ~cur_ff.fault_prev;
   end

   // next state of the whole block
   always_comb begin
      nxt_ff            = cur_ff;
      nxt_ff.txe_prev   = pin_txe_s;
      nxt_ff.fault_prev = link_fault;
      nxt_ff.present    = 1'b1;

      // reset sequencer; a low pin level always means reset
      unique case (cur_ff.seq)
         SEQ_RUN: begin
            if (!pin_rst_n_s) begin
               nxt_ff.seq = SEQ_PIN_LOW;
            end else if (soft_reset) begin
               nxt_ff.seq      = SEQ_INIT;
               nxt_ff.init_cnt = '0;
               nxt_ff.rst_bits = DEV_IMPL;
            end
         end
         SEQ_PIN_LOW: begin
            // transient: pin low, bit still clear, set it now
            nxt_ff.seq                = SEQ_HELD;
            nxt_ff.rst_bits           = DEV_IMPL;
            nxt_ff.rst_bits[DEV1_SLOT] = 1'b1;
         end
         SEQ_HELD: begin
            // held until the pin is released; its width is the host's job
            if (pin_rst_n_s) begin
               nxt_ff.seq      = SEQ_INIT;
               nxt_ff.init_cnt = '0;
            end
         end
         SEQ_INIT: begin
            if (!pin_rst_n_s) begin
               nxt_ff.seq = SEQ_HELD;
            end else if (soft_reset) begin
               nxt_ff.init_cnt = '0;
            end else if (init_done) begin
               // bits clear only once initialisation has finished
               nxt_ff.seq       = SEQ_RUN;
               nxt_ff.rst_bits  = '0;
               nxt_ff.port_addr = pin_addr_s;
               nxt_ff.low_power = cur_ff.lps_en &
                                  ~pin_txe_s;
            end else begin
               nxt_ff.init_cnt = cur_ff.init_cnt + 32'd1;
            end
         end
      endcase

      // low-power hold ends when the host raises transmit-enable
      if ((cur_ff.seq == SEQ_RUN) & pin_txe_s) begin
         nxt_ff.low_power = 1'b0;
      end

      // laser gate: pin low forces off whatever else holds
      nxt_ff.tx_on = pin_txe_s & (nxt_ff.seq == SEQ_RUN) &
                     ~nxt_ff.low_power;
      nxt_ff.dp_en = (nxt_ff.seq == SEQ_RUN) & ~nxt_ff.low_power;

      // management answers only to the loaded port address
      nxt_ff.addr_match = (mgmt_target_addr == cur_ff.port_addr) &
                          (cur_ff.seq == SEQ_RUN);

      // register writes
      if (wr_acc & (sel == SEL_CTRL) & wmask[CTRL_LPS_BIT]) begin
         nxt_ff.lps_en = pwdata[CTRL_LPS_BIT];
      end
      if (wr_acc & (sel == SEL_ENABLE)) begin
         nxt_ff.enable = (cur_ff.enable & ~wmask[EV_W-1:0]) |
                         (pwdata[EV_W-1:0] & wmask[EV_W-1:0]);
      end

      // sticky status: a new event wins over a same-cycle clear
      if (wr_acc & (sel == SEL_CLEAR)) begin
         nxt_ff.status = cur_ff.status &
                         ~(pwdata[EV_W-1:0] & wmask[EV_W-1:0]);
      end
      nxt_ff.status = nxt_ff.status | events;

      // read data is captured in the setup phase
      if (rd_setup) begin
         nxt_ff.rdata = '0;
         unique case (sel)
            SEL_CTRL: begin
               nxt_ff.rdata[CTRL_RESET_BIT] = cur_ff.rst_bits[DEV1_SLOT];
               nxt_ff.rdata[CTRL_LPS_BIT]   = cur_ff.lps_en;
            end
            SEL_STATUS: nxt_ff.rdata[EV_W-1:0] = cur_ff.status;
            SEL_ENABLE: nxt_ff.rdata[EV_W-1:0] = cur_ff.enable;
            SEL_STATE: begin
               nxt_ff.rdata[ST_RSTBITS_LSB +: DEV_SLOTS] = cur_ff.rst_bits;
               nxt_ff.rdata[ST_PORT_LSB +: PORT_ADDR_W]  = cur_ff.port_addr;
               nxt_ff.rdata[ST_SEQ_LSB +: 2]             = cur_ff.seq;
               nxt_ff.rdata[ST_LOWPWR_BIT]               = cur_ff.low_power;
               nxt_ff.rdata[ST_TXON_BIT]                 = cur_ff.tx_on;
               nxt_ff.rdata[ST_DPEN_BIT]                 = cur_ff.dp_en;
               nxt_ff.rdata[ST_PINRST_BIT]               = pin_rst_n_s;
               nxt_ff.rdata[ST_PINTXE_BIT]               = pin_txe_s;
            end
            SEL_CLEAR:  nxt_ff.rdata = '0;
            SEL_NONE:   nxt_ff.rdata = '0;
         endcase
      end
   end

   // power-up counts as a reset: start in initialisation, bits set
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur_ff.seq        <= SEQ_INIT;
         cur_ff.rst_bits   <= DEV_IMPL;
         cur_ff.init_cnt   <= '0;
         cur_ff.low_power  <= 1'b0;
         cur_ff.lps_en     <= CTRL_LPS_RST;
         cur_ff.port_addr  <= '0;
         cur_ff.addr_match <= 1'b0;
         cur_ff.tx_on      <= 1'b0;
         cur_ff.dp_en      <= 1'b0;
         cur_ff.present    <= 1'b1;
         cur_ff.txe_prev   <= 1'b1;
         cur_ff.fault_prev <= 1'b0;
         cur_ff.status     <= '0;
         cur_ff.enable     <= ENABLE_RST;
         cur_ff.rdata      <= '0;
      end else if (ce) begin
         cur_ff <= nxt_ff;
      end
   end

   // interrupt level, also shown on the link alarm line
   assign alarm = |(cur_ff.status & cur_ff.enable);
   assign irq   = alarm;

   // open drain: only ever pull low, never drive high
   assign link_alarm_line_out     = 1'b0;
   assign link_alarm_line_oe      = alarm;
   assign module_present_line_out = 1'b0;
   assign module_present_line_oe  = cur_ff.present;

   // registered outputs; laser off within a few cycles of the pin
   assign tx_laser_on      = cur_ff.tx_on;
   assign datapath_enable  = cur_ff.dp_en;
   assign low_power_active = cur_ff.low_power;
   assign port_address     = cur_ff.port_addr;
   assign dev_reset_bits   = cur_ff.rst_bits;
   assign mgmt_addr_match  = cur_ff.addr_match;
   assign prdata           = cur_ff.rdata;

endmodule : module_reset_and_tx_control
`default_nettype wire

// [logic/pin_sync.sv]
// two-stage synchroniser for the slow control pins
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
   parameter int unsigned       WIDTH     = 7,
   parameter logic [WIDTH-1:0]  RESET_VAL = '0
) (
   // clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             ce,
   // pins and synchronised copy
   input  wire logic [WIDTH-1:0] pins_in,
   output logic      [WIDTH-1:0] pins_sync
);

   typedef struct packed {
      logic [WIDTH-1:0] stage1;
      logic [WIDTH-1:0] stage2;
   } sync_state_type;

   sync_state_type cur_ff;
   sync_state_type nxt_ff;

   // first stage feeds only the second stage
   always_comb begin
      nxt_ff        = cur_ff;
      nxt_ff.stage1 = pins_in;
      nxt_ff.stage2 = cur_ff.stage1;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur_ff <= {RESET_VAL, RESET_VAL};
      end else if (ce) begin
         cur_ff <= nxt_ff;
      end
   end

   assign pins_sync = cur_ff.stage2;

endmodule : pin_sync
`default_nettype wire

// [test/host_pins_model.sv]
// host side model of the slow control pins, with the module's pull-ups
`timescale 1ns/10ps
`default_nettype none
module host_pins_model #(
   parameter int unsigned MIN_LOW = 40
) (
   // clock
   input  wire logic       pclk,
   // bench requests
   input  wire logic       rst_req,
   input  wire logic       txe_off,
   input  wire logic [4:0] addr_set,
   // resolved pin levels
   output logic            reset_pin_n,
   output logic            tx_enable_pin,
   output logic [4:0]      port_addr_pins
);
   int unsigned low_cnt = 0;
   logic        pull_rst;

   // once asked, reset stays low for the whole minimum time
   assign pull_rst = rst_req || (low_cnt != 0 && low_cnt < MIN_LOW);
   always_ff @(posedge pclk) begin
      low_cnt <= pull_rst ? low_cnt + 1 : 0;
   end

   // open-drain drivers: released lines float high via pull-ups
   assign reset_pin_n    = pull_rst ? 1'b0 : 1'b1;
   assign tx_enable_pin  = txe_off ? 1'b0 : 1'b1;
   assign port_addr_pins = addr_set;               // straps, held steady
endmodule : host_pins_model
`default_nettype wire

// [test/module_reset_and_tx_control_monitor.sv]
// concurrent checks on the ports of the reset and transmit control block
`timescale 1ns/10ps
`default_nettype none
module module_reset_and_tx_control_monitor
   import module_ctrl_pkg::*;
#(
   parameter int unsigned INIT_CYCLES = 8,
   parameter logic [5:0]  DEV_IMPL    = 6'h3F
) (
   // clock and reset
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   // register bus
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [APB_AW-1:0]     paddr,
   input  wire logic [31:0]           pwdata,
   input  wire logic [3:0]            pstrb,
   // pins and status
   input  wire logic                  reset_pin_n,
   input  wire logic                  tx_enable_pin,
   input  wire logic                  link_alarm_line_out,
   input  wire logic                  link_alarm_line_oe,
   input  wire logic                  module_present_line_out,
   input  wire logic                  module_present_line_oe,
   input  wire logic [DEV_SLOTS-1:0]  dev_reset_bits,
   input  wire logic                  tx_laser_on,
   input  wire logic                  datapath_enable,
   input  wire logic                  irq
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   property p_alarm;
      link_alarm_line_oe == irq;
   endproperty
   a_alarm: assert property (p_alarm)
      else $error("alarm pull-down not following interrupt");
   property p_drain;
      !link_alarm_line_out && !module_present_line_out;
   endproperty
   a_drain: assert property (p_drain)
      else $error("status line driven high");
   property p_present;
      module_present_line_oe;
   endproperty
   a_present: assert property (p_present)
      else $error("module present line released");
   property p_tx_off;
      $fell(tx_enable_pin) |-> ##[1:4] !tx_laser_on;
   endproperty
   a_tx_off: assert property (p_tx_off)
      else $error("laser still on after transmit disable");
   property p_tx_low;
      !tx_enable_pin [*4] |-> !tx_laser_on;
   endproperty
   a_tx_low: assert property (p_tx_low)
      else $error("laser on while transmit disabled");
   property p_pin_rst;
      !reset_pin_n [*6] |-> dev_reset_bits[DEV1_SLOT];
   endproperty
   a_pin_rst: assert property (p_pin_rst)
      else $error("reset bit not set after reset pin low");
   property p_gate;
      // same cycle: bits and laser leave reset at one edge
      dev_reset_bits[DEV1_SLOT] |-> !tx_laser_on && !datapath_enable;
   endproperty
   a_gate: assert property (p_gate)
      else $error("datapath running while in reset");
   property p_clear;
      $fell(dev_reset_bits[DEV1_SLOT]) |-> dev_reset_bits == 6'h00;
   endproperty
   a_clear: assert property (p_clear)
      else $error("reset bits not cleared together");
   property p_soft;
      psel && penable && pwrite && paddr == REG_CTRL && pwdata[15]
         && pstrb[1] |=> dev_reset_bits == DEV_IMPL;
   endproperty
   a_soft: assert property (p_soft)
      else $error("soft reset write did not set reset bits");
endmodule : module_reset_and_tx_control_monitor
`default_nettype wire

// [test/module_reset_and_tx_control_tb.sv]
// self-checking bench for the reset and transmit control block
`timescale 1ns/10ps
`default_nettype none
module module_reset_and_tx_control_tb;
   import module_ctrl_pkg::*;
   localparam int unsigned INIT_N = 8;
   logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rdata;
   logic [3:0]  pstrb;
   logic        rst_req, txe_off, reset_pin_n, tx_enable_pin, link_fault;
   logic [4:0]  addr_set, pa, mgmt_target_addr, port_address;
   logic        al_out, al_oe, mp_out, mp_oe, mgmt_addr_match, rerr;
   logic [5:0]  dev_reset_bits;
   logic        tx_laser_on, datapath_enable, low_power_active, irq;
   int          error_cnt = 0;
   int          compares = 0;

   // host pins and device under test
   host_pins_model #(.MIN_LOW(40)) host (.pclk, .rst_req, .txe_off,
      .addr_set, .reset_pin_n, .tx_enable_pin, .port_addr_pins(pa));
   module_reset_and_tx_control #(.INIT_CYCLES(INIT_N)) dut (.pclk, .presetn,
      .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
      .pready, .pslverr, .reset_pin_n, .tx_enable_pin,
      .port_address_bit4(pa[4]), .port_address_bit3(pa[3]),
      .port_address_bit2(pa[2]), .port_address_bit1(pa[1]),
      .port_address_bit0(pa[0]), .link_alarm_line_out(al_out),
      .link_alarm_line_oe(al_oe), .module_present_line_out(mp_out),
      .module_present_line_oe(mp_oe), .link_fault, .mgmt_target_addr,
      .mgmt_addr_match, .port_address, .dev_reset_bits, .tx_laser_on,
      .datapath_enable, .low_power_active, .irq);

   // 200 MHz clock
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : end_of_test

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   // one apb transfer; holds everything until pready is seen high
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // no cycle limit here: only the watchdog ends a stuck wait
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rdata = prdata;
      rerr  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   // poll until every device reset bit reads clear
   task automatic wait_run();
      apb(1'b0, REG_STATE, 32'h0);
      while (rdata[5:0] !== 6'h00) begin
         apb(1'b0, REG_STATE, 32'h0);
      end
   endtask : wait_run

   task automatic t_init();
      wait_run();
      check(dev_reset_bits, 6'h00);
      check(port_address, 5'h15);
      mgmt_target_addr <= 5'h15;
      repeat (3) @(posedge pclk);
      check(mgmt_addr_match, 1'h1);
      mgmt_target_addr <= 5'h0A;
      repeat (3) @(posedge pclk);
      check(mgmt_addr_match, 1'h0);
      check(tx_laser_on, 1'h1);
      check({mp_oe, mp_out}, 2'h2);
      check({irq, al_oe, al_out}, 3'h0);
      apb(1'b0, 8'h40, 32'h0);
      check({rerr, pready}, 2'h3);
      check(rdata, 32'h0);
   endtask : t_init

   task automatic t_irq_tx();
      apb(1'b1, REG_CLEAR, 32'hF);
      apb(1'b1, REG_ENABLE, 32'hC);
      txe_off <= 1'b1;
      repeat (6) @(posedge pclk);
      check(tx_laser_on, 1'h0);
      check({irq, al_oe}, 2'h3);
      apb(1'b1, REG_ENABLE, 32'h0);
      check({irq, al_oe}, 2'h0);
      link_fault <= 1'b1;
      repeat (4) @(posedge pclk);
      apb(1'b0, REG_STATUS, 32'h0);
      check(rdata, 32'hC);
      apb(1'b1, REG_CLEAR, 32'hC);
      apb(1'b0, REG_STATUS, 32'h0);
      check(rdata, 32'h0);
      txe_off    <= 1'b0;
      link_fault <= 1'b0;
      repeat (6) @(posedge pclk);
      check(tx_laser_on, 1'h1);
   endtask : t_irq_tx

   task automatic t_pin_reset();
      apb(1'b1, REG_ENABLE, 32'h1);
      rst_req <= 1'b1;
      @(posedge pclk);
      rst_req <= 1'b0;
      repeat (8) @(posedge pclk);
      check(dev_reset_bits, 6'h3F);
      check(datapath_enable, 1'h0);
      apb(1'b0, REG_CTRL, 32'h0);
      check(rdata[15], 1'h1);
      wait_run();
      check({irq, datapath_enable}, 2'h3);
      apb(1'b1, REG_CLEAR, 32'h1);
   endtask : t_pin_reset

   task automatic t_soft();
      addr_set <= 5'h0A;
      apb(1'b1, REG_CTRL, 32'h8000);
      apb(1'b0, REG_CTRL, 32'h0);
      check(rdata[15], 1'h1);
      check(tx_laser_on, 1'h0);
      wait_run();
      apb(1'b0, REG_CTRL, 32'h0);
      check(rdata[15], 1'h0);
      check(port_address, 5'h0A);
   endtask : t_soft

   task automatic t_lps();
      txe_off <= 1'b1;
      apb(1'b1, REG_CTRL, 32'h8001);
      wait_run();
      check({low_power_active, datapath_enable}, 2'h2);
      mgmt_target_addr <= 5'h0A;
      repeat (3) @(posedge pclk);
      check(mgmt_addr_match, 1'h1);
      txe_off <= 1'b0;
      repeat (6) @(posedge pclk);
      check({low_power_active, tx_laser_on}, 2'h1);
   endtask : t_lps

   // clock enable low freezes the registered address match
   task automatic t_ce();
      ce               <= 1'b0;
      mgmt_target_addr <= 5'h15;
      repeat (4) @(posedge pclk);
      check(mgmt_addr_match, 1'h1);
      ce <= 1'b1;
      repeat (3) @(posedge pclk);
      check(mgmt_addr_match, 1'h0);
   endtask : t_ce

   // main sequence
   initial begin
      {psel, penable, pwrite, rst_req, txe_off, link_fault} = 6'h00;
      ce               = 1'b1;
      paddr            = 8'h00;
      pwdata           = 32'h0;
      pstrb            = 4'hF;
      addr_set         = 5'h15;
      mgmt_target_addr = 5'h00;
      presetn          = 1'b0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_init();
      t_irq_tx();
      t_pin_reset();
      t_soft();
      t_lps();
      t_ce();
      end_of_test();
   end

   // watchdog: the whole run needs a few hundred cycles
   initial begin
      repeat (20000) @(posedge pclk);
      error_cnt++;
      end_of_test();
   end
endmodule : module_reset_and_tx_control_tb

bind module_reset_and_tx_control module_reset_and_tx_control_monitor #(
   .INIT_CYCLES(INIT_CYCLES), .DEV_IMPL(DEV_IMPL)) mon (.pclk, .presetn,
   .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .reset_pin_n,
   .tx_enable_pin, .link_alarm_line_out, .link_alarm_line_oe,
   .module_present_line_out, .module_present_line_oe, .dev_reset_bits,
   .tx_laser_on, .datapath_enable, .irq);
`default_nettype wire
